// >>> tio_defines.svh
// Offsets, field positions and reset values of the channel 0 I/O control
`ifndef TIO_DEFINES_SVH
`define TIO_DEFINES_SVH
`define IO_CTRL_HIGH_ADDR 4'h0
`define IO_CTRL_LOW_ADDR 4'h1
`define IO_FIELD_LSB 0
`define IO_FIELD_MSB 3
`define IO_CTRL_RESET 8'h00
`define IO_SEL_BIT2 2
`endif

// >>> tio_pkg.sv
// Types for the channel 0 I/O mode selection
`default_nettype none
package tio_pkg;
  typedef enum logic [1:0] {
    act_none,
    act_low,
    act_high,
    act_toggle
  } cmp_action_t;
  typedef struct packed {
    logic [7:0] ctrl_high;
    logic [7:0] ctrl_low;
    logic pin_a;
    logic pin_c;
    logic pin_a_en;
    logic pin_c_en;
    logic pin_a_prev;
    logic pin_c_prev;
    logic cap_a;
    logic cap_c;
    logic [7:0] rdata;
  } tio_state_t;
endpackage
`default_nettype wire

// >>> timer_ch0_io_mode_select.sv
// Channel 0 pin I/O mode selection for general registers A and C
//
// Decided for this implementation: the address map and the strobed register port.
`include "tio_defines.svh"
`default_nettype none
module timer_ch0_io_mode_select
  import tio_pkg::*;
(
  input wire logic clk, // 25 MHz timer clock
  input wire logic reset, // Async, active high
  input wire logic [3:0] addr, // Register address
  input wire logic [7:0] wdata, // Write data
  input wire logic wr, // Write strobe
  input wire logic rd, // Read strobe
  output logic [7:0] rdata, // Read data, cycle after rd
  input wire logic buffer_mode_a_pair, // Register C is buffer
  input wire logic match_a, // Compare match A strobe
  input wire logic match_c, // Compare match C strobe
  input wire logic ch0_pin_a_in, // Pin A input level
  input wire logic ch0_pin_c_in, // Pin C input level
  output logic ch0_pin_a_out, // Pin A output level
  output logic ch0_pin_a_oe, // Pin A output enable
  output logic ch0_pin_c_out, // Pin C output level
  output logic ch0_pin_c_oe, // Pin C output enable
  output logic capture_a, // Capture counter into reg A
  output logic capture_c, // Capture counter into reg C
  output logic compare_a_en, // Reg A acts as compare
  output logic compare_c_en // Reg C acts as compare
);

  tio_state_t st;
  tio_state_t next_st;

  function automatic cmp_action_t action_of(input logic [3:0] f);
    if (f[3]) begin
      action_of = act_none;
    end else begin
      case (f[1:0])
        2'h1: action_of = act_low;
        2'h2: action_of = act_high;
        2'h3: action_of = act_toggle;
        default: action_of = act_none;
      endcase
    end
  endfunction

  function automatic logic cap_hit(input logic [3:0] f, input logic prev,
                                   input logic cur);
    cap_hit = 1'b0;
    if (f[3:2] == 2'h2) begin
      case (f[1:0])
        2'h0: cap_hit = !prev && cur;
        2'h1: cap_hit = prev && !cur;
        default: cap_hit = prev != cur;
      endcase
    end
  endfunction

  function automatic logic pin_next(input cmp_action_t a, input logic cur);
    case (a)
      act_low: pin_next = 1'b0;
      act_high: pin_next = 1'b1;
      act_toggle: pin_next = !cur;
      default: pin_next = cur;
    endcase
  endfunction

  logic [3:0] fa;
  logic [3:0] fc;
  logic c_live;
  assign fa = st.ctrl_high[`IO_FIELD_MSB:`IO_FIELD_LSB];
  assign fc = st.ctrl_low[`IO_FIELD_MSB:`IO_FIELD_LSB];
  assign c_live = !buffer_mode_a_pair;

  always_comb begin
    next_st = st;
    next_st.pin_a_prev = ch0_pin_a_in;
    next_st.pin_c_prev = ch0_pin_c_in;
    next_st.cap_a = cap_hit(fa, st.pin_a_prev, ch0_pin_a_in);
    next_st.cap_c = c_live && cap_hit(fc, st.pin_c_prev, ch0_pin_c_in);
    next_st.rdata = 8'h00;
    if (rd && addr == `IO_CTRL_HIGH_ADDR) begin
      next_st.rdata = st.ctrl_high;
    end else if (rd && addr == `IO_CTRL_LOW_ADDR) begin
      next_st.rdata = st.ctrl_low;
    end
    // Compare actions use the field in force before any write.
    // A match on a capture or disabled code leaves the level alone.
    if (match_a) begin
      next_st.pin_a = pin_next(action_of(fa), st.pin_a);
    end
    if (match_c && c_live) begin
      next_st.pin_c = pin_next(action_of(fc), st.pin_c);
    end
    next_st.pin_a_en = !fa[3] && fa[1:0] != 2'h0;
    next_st.pin_c_en = c_live && !fc[3] && fc[1:0] != 2'h0;
    // A write reloads the initial level from bit 2.
    // Placed last so a write in the same cycle as a match wins.
    if (wr && addr == `IO_CTRL_HIGH_ADDR) begin
      next_st.ctrl_high = {4'h0, wdata[3:0]};
      next_st.pin_a = wdata[`IO_SEL_BIT2];
    end
    if (wr && addr == `IO_CTRL_LOW_ADDR) begin
      next_st.ctrl_low = {4'h0, wdata[3:0]};
      next_st.pin_c = wdata[`IO_SEL_BIT2];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign ch0_pin_a_out = st.pin_a;
  assign ch0_pin_c_out = st.pin_c;
  assign ch0_pin_a_oe = st.pin_a_en;
  assign ch0_pin_c_oe = st.pin_c_en;
  assign capture_a = st.cap_a;
  assign capture_c = st.cap_c;
  assign compare_a_en = !fa[3] && fa[1:0] != 2'h0;
  assign compare_c_en = c_live && !fc[3] && fc[1:0] != 2'h0;

  low_match_a: assert property (@(posedge clk) disable iff (reset)
    match_a && !fa[3] && fa[1:0] == 2'h1 && !wr |=> !ch0_pin_a_out)
    else $error("pin A not low after match");
  high_match_a: assert property (@(posedge clk) disable iff (reset)
    match_a && !fa[3] && fa[1:0] == 2'h2 && !wr |=> ch0_pin_a_out)
    else $error("pin A not high after match");
  toggle_match_c: assert property (@(posedge clk) disable iff (reset)
    match_c && c_live && !fc[3] && fc[1:0] == 2'h3 && !wr
    |=> ch0_pin_c_out != $past(ch0_pin_c_out))
    else $error("pin C did not toggle");
  rise_cap_a: assert property (@(posedge clk) disable iff (reset)
    fa == 4'h8 && !st.pin_a_prev && ch0_pin_a_in |=> capture_a)
    else $error("rising capture missed");
  fall_cap_a: assert property (@(posedge clk) disable iff (reset)
    fa == 4'h9 && st.pin_a_prev && !ch0_pin_a_in |=> capture_a)
    else $error("falling capture missed");
  both_cap_c: assert property (@(posedge clk) disable iff (reset)
    fc[3:2] == 2'h2 && fc[1] && c_live &&
    st.pin_c_prev != ch0_pin_c_in |=> capture_c)
    else $error("both-edge capture missed");
  buffer_quiet_c: assert property (@(posedge clk) disable iff (reset)
    buffer_mode_a_pair [*2] |-> !capture_c && !compare_c_en)
    else $error("register C active in buffer mode");
  disabled_out_a: assert property (@(posedge clk) disable iff (reset)
    ##1 $past(fa[1:0]) == 2'h0 |-> !ch0_pin_a_oe)
    else $error("pin A driven while disabled");

  // Compare actions on the other register of each pair
  low_match_c_a: assert property (@(posedge clk) disable iff (reset)
    match_c && c_live && !fc[3] && fc[1:0] == 2'h1 && !wr
    |=> !ch0_pin_c_out)
    else $error("pin C not low after match");

  high_match_c_a: assert property (@(posedge clk) disable iff (reset)
    match_c && c_live && !fc[3] && fc[1:0] == 2'h2 && !wr
    |=> ch0_pin_c_out)
    else $error("pin C not high after match");

  toggle_match_a_a: assert property (@(posedge clk) disable iff (reset)
    match_a && !fa[3] && fa[1:0] == 2'h3 && !wr
    |=> ch0_pin_a_out != $past(ch0_pin_a_out))
    else $error("pin A did not toggle");

  // Initial level comes from bit 2 of the written field
  init_level_a_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == `IO_CTRL_HIGH_ADDR
    |=> ch0_pin_a_out == $past(wdata[`IO_SEL_BIT2]))
    else $error("pin A initial level wrong");

  init_level_c_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == `IO_CTRL_LOW_ADDR
    |=> ch0_pin_c_out == $past(wdata[`IO_SEL_BIT2]))
    else $error("pin C initial level wrong");

  // Levels only move on a match or a write
  hold_pin_a_a: assert property (@(posedge clk) disable iff (reset)
    !match_a && !(wr && addr == `IO_CTRL_HIGH_ADDR)
    |=> $stable(ch0_pin_a_out))
    else $error("pin A moved without cause");

  hold_pin_c_a: assert property (@(posedge clk) disable iff (reset)
    !(match_c && c_live) && !(wr && addr == `IO_CTRL_LOW_ADDR)
    |=> $stable(ch0_pin_c_out))
    else $error("pin C moved without cause");

  // Capture edges for both registers
  rise_cap_c_a: assert property (@(posedge clk) disable iff (reset)
    c_live && fc == 4'h8 && !st.pin_c_prev && ch0_pin_c_in |=> capture_c)
    else $error("rising capture C missed");

  fall_cap_c_a: assert property (@(posedge clk) disable iff (reset)
    c_live && fc == 4'h9 && st.pin_c_prev && !ch0_pin_c_in |=> capture_c)
    else $error("falling capture C missed");

  both_cap_a_a: assert property (@(posedge clk) disable iff (reset)
    fa[3:2] == 2'h2 && fa[1] && st.pin_a_prev != ch0_pin_a_in
    |=> capture_a)
    else $error("both-edge capture A missed");

  rise_only_a_a: assert property (@(posedge clk) disable iff (reset)
    fa == 4'h8 && !(!st.pin_a_prev && ch0_pin_a_in) |=> !capture_a)
    else $error("capture A on a non-rising edge");

  fall_only_a_a: assert property (@(posedge clk) disable iff (reset)
    fa == 4'h9 && !(st.pin_a_prev && !ch0_pin_a_in) |=> !capture_a)
    else $error("capture A on a non-falling edge");

  no_cap_a_a: assert property (@(posedge clk) disable iff (reset)
    fa[3:2] != 2'h2 |=> !capture_a)
    else $error("capture A outside capture codes");

  no_cap_c_a: assert property (@(posedge clk) disable iff (reset)
    fc[3:2] != 2'h2 |=> !capture_c)
    else $error("capture C outside capture codes");

  // Output enables trail the compare enables by one cycle
  oe_follow_a_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> ch0_pin_a_oe == $past(compare_a_en))
    else $error("pin A enable does not follow field");

  oe_follow_c_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> ch0_pin_c_oe == $past(compare_c_en))
    else $error("pin C enable does not follow field");

  buffer_oe_c_a: assert property (@(posedge clk) disable iff (reset)
    buffer_mode_a_pair [*2] |-> !ch0_pin_c_oe)
    else $error("pin C driven in buffer mode");

  prohibited_a_a: assert property (@(posedge clk) disable iff (reset)
    fa[3:2] == 2'h3 |-> !compare_a_en && !ch0_pin_a_oe ##1 !capture_a)
    else $error("prohibited code A active");

  // Register access: only the low nibble is kept
  read_high_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == `IO_CTRL_HIGH_ADDR |=> rdata == {4'h0, $past(fa)})
    else $error("read of field A wrong");

  read_low_a: assert property (@(posedge clk) disable iff (reset)
    rd && addr == `IO_CTRL_LOW_ADDR |=> rdata == {4'h0, $past(fc)})
    else $error("read of field C wrong");

  read_idle_a: assert property (@(posedge clk) disable iff (reset)
    !rd |=> rdata == 8'h00)
    else $error("read data not zero when idle");

  upper_zero_a: assert property (@(posedge clk) disable iff (reset)
    st.ctrl_high[7:4] == 4'h0 && st.ctrl_low[7:4] == 4'h0)
    else $error("upper field bits not zero");

  field_write_a_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == `IO_CTRL_HIGH_ADDR |=> fa == $past(wdata[3:0]))
    else $error("field A write lost");

  field_write_c_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr == `IO_CTRL_LOW_ADDR |=> fc == $past(wdata[3:0]))
    else $error("field C write lost");

  // Unmapped addresses must not disturb either field
  unmapped_wr_a: assert property (@(posedge clk) disable iff (reset)
    wr && addr != `IO_CTRL_HIGH_ADDR && addr != `IO_CTRL_LOW_ADDR
    |=> $stable(fa) && $stable(fc))
    else $error("unmapped write changed a field");

endmodule // timer_ch0_io_mode_select
`default_nettype wire

// >>> tio_pin_model.sv
// Far-side pin drivers for the channel 0 pins
`default_nettype none
module tio_pin_model (
  input wire logic ext_a, // Outside level on pin A
  input wire logic ext_c, // Outside level on pin C
  input wire logic out_a, // Block level on pin A
  input wire logic oe_a, // Block drives pin A
  input wire logic out_c, // Block level on pin C
  input wire logic oe_c, // Block drives pin C
  output logic pin_a, // Resolved pin A
  output logic pin_c // Resolved pin C
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block drive wins, so a captured edge may come from the block itself
  assign pin_a = oe_a ? out_a : ext_a;
  assign pin_c = oe_c ? out_c : ext_c;
endmodule // tio_pin_model
`default_nettype wire

// >>> tb_timer_ch0_io_mode_select.sv
// Self-checking bench for the channel 0 I/O mode selection
`default_nettype none
module tb_timer_ch0_io_mode_select;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, wr = 0, rd = 0, bufm = 0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00, rdata;
  logic [1:0] mt = 2'h0, ext = 2'h0, pin, outv, oev, cap, cmp;
  int error_cnt = 0, tests_run = 0, cyc = 0;
  always #20 clk = ~clk;
  timer_ch0_io_mode_select u_dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .buffer_mode_a_pair(bufm), .match_a(mt[0]), .match_c(mt[1]),
    .ch0_pin_a_in(pin[0]), .ch0_pin_c_in(pin[1]),
    .ch0_pin_a_out(outv[0]), .ch0_pin_a_oe(oev[0]),
    .ch0_pin_c_out(outv[1]), .ch0_pin_c_oe(oev[1]),
    .capture_a(cap[0]), .capture_c(cap[1]),
    .compare_a_en(cmp[0]), .compare_c_en(cmp[1]));
  tio_pin_model u_pins (.ext_a(ext[0]), .ext_c(ext[1]), .out_a(outv[0]),
    .oe_a(oev[0]), .out_c(outv[1]), .oe_c(oev[1]), .pin_a(pin[0]),
    .pin_c(pin[1]));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checks=%0d errors=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // Output enable trails the field by one cycle
    @(posedge clk);
    #1;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic pulse(input int r);
    @(posedge clk);
    mt[r] <= 1'b1;
    @(posedge clk);
    mt[r] <= 1'b0;
    #1;
  endtask
  // Window of four cycles tolerates the edge detector's latency
  task automatic count(input int r, input logic lvl, output logic [7:0] n);
    @(posedge clk);
    ext[r] <= lvl;
    n = 8'h00;
    repeat (4) begin
      @(posedge clk);
      #1;
      n = n + {7'h00, cap[r]};
    end
  endtask
  function automatic logic [7:0] vis(input int r);
    return {6'h00, oev[r], oev[r] & outv[r]};
  endfunction
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      end_of_test();
    end
  end
  initial begin
    logic [7:0] n;
    logic [1:0] e;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    for (int r = 0; r < 2; r++) begin
      rd_reg(r[3:0], n);
      chk(n, 8'h00);
    end
    wr_reg(4'h2, 8'h07);
    rd_reg(4'h2, n);
    chk(n, 8'h00);
    // Codes 11xx are prohibited for software, so stop at 1011
    for (int c = 0; c < 12; c++) begin
      for (int r = 0; r < 2; r++) begin
        wr_reg(r[3:0], 8'hF0 | c[7:0]);
        rd_reg(r[3:0], n);
        chk(n, c[7:0]);
        e = (c < 8 && c[1:0] != 0) ? {1'b1, c[2]} : 2'h0;
        chk(vis(r), {6'h00, e});
        chk({7'h00, cmp[r]}, {7'h00, e[1]});
        pulse(r);
        if (e[1])
          e[0] = c[1:0] == 1 ? 1'b0 : c[1:0] == 2 ? 1'b1 : ~c[2];
        chk(vis(r), {6'h00, e});
        count(r, 1'b0, n);
        count(r, 1'b1, n);
        chk(n, {7'h00, c == 8 || c == 10 || c == 11});
        count(r, 1'b0, n);
        chk(n, {7'h00, c == 9 || c == 10 || c == 11});
      end
    end
    bufm <= 1'b1;
    wr_reg(4'h1, 8'h07);
    pulse(1);
    chk(vis(1), 8'h00);
    chk({7'h00, cmp[1]}, 8'h00);
    wr_reg(4'h1, 8'h0A);
    count(1, 1'b1, n);
    chk(n, 8'h00);
    end_of_test();
  end
endmodule // tb_timer_ch0_io_mode_select
`default_nettype wire
